// ==== rtl/config_memory_crc_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module config_memory_crc_checker
   import crc_chk_pkg::*;
#(
   parameter int NUM_FRAMES = 4,
   parameter int FRAME_WORDS = 4
)
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic reconfig_request_low_in,
   input wire logic cfg_word_valid_in,
   input wire logic [WORD_W-1:0] cfg_word_in,
   input wire logic cfg_crc_valid_in,
   input wire logic [CRC_W-1:0] cfg_crc_in,
   input wire logic cfg_done_in,
   input wire logic det_enable_in,
   input wire logic [2:0] det_div_exp_in,
   input wire logic user_io_out_in,
   input wire logic user_io_oe_in,
   input wire logic [IR_W-1:0] jtag_ir_in,
   input wire jtag_ctl_t jtag_ctl_in,
   input wire user_ctl_t user_ctl_in,
   output logic cfg_health_low_out,
   output logic crc_error_out,
   output logic crc_error_pin_out,
   output logic crc_error_pin_oe_out,
   output logic jtag_tdo_out,
   output logic user_data_out
);

   localparam int ADDR_W = $clog2(NUM_FRAMES * FRAME_WORDS);
   localparam int FIDX_W = $clog2(NUM_FRAMES);
   localparam int WIDX_W = $clog2(FRAME_WORDS);
   localparam int POS_W = WIDX_W + 5;
   localparam logic [FIDX_W-1:0] LAST_F = FIDX_W'(NUM_FRAMES - 1);
   localparam logic [WIDX_W-1:0] LAST_W = WIDX_W'(FRAME_WORDS - 1);
   localparam logic [POS_W-1:0] LAST_POS = POS_W'(FRAME_WORDS * WORD_W - 1);

   typedef enum logic [2:0] {ST_CONFIG, ST_START, ST_CALC, ST_EVAL, ST_SEARCH,
                             ST_WAIT, ST_REPORT, ST_FLAG} state_t;

   function automatic logic [ADDR_W-1:0] word_addr(input logic [FIDX_W-1:0] f,
                                                   input logic [WIDX_W-1:0] w);
      word_addr = ADDR_W'(f * FRAME_WORDS + w);
   endfunction

   function automatic logic [WORD_W-1:0] burst_mask(input logic [1:0] len_m1,
                                                    input logic [4:0] bi);
      logic [3:0] m;
      m = 4'((5'h02 << len_m1) - 5'h01);
      burst_mask = {28'h0000000, m} << bi;
   endfunction

   logic [WORD_W-1:0] mem [NUM_FRAMES*FRAME_WORDS];
   logic [CRC_W-1:0] crc_mem [NUM_FRAMES];

   state_t st_q;
   logic rc_meta_q, rc_sync_q;
   logic [7:0] div_cnt_q;
   logic [CRC_W-1:0] crc_run_q, syn_q, s_crc_q;
   logic [FIDX_W-1:0] cfg_f_q, chk_f_q;
   logic [WIDX_W-1:0] cfg_w_q, chk_w_q, s_word_q;
   logic [POS_W-1:0] s_pos_q, hit_pos_q;
   logic [1:0] s_len_q;
   logic [4:0] hit_type_q;
   logic [5:0] low_cnt_q;
   logic health_q, err_q, pin_q, pin_oe_q, tdo_q;
   emr_t emr_q, jt_upd_q, usr_upd_q;
   logic emr_valid_q;
   logic [EMR_W-1:0] jt_sh_q, usr_sh_q;
   logic jt_pend_q, usr_pend_q;
   logic [INJ_W-1:0] inj_sh_q;
   inj_t inj_q;

   // decoding
   wire reconfig = ~rc_sync_q;
   wire [7:0] div_lim = 8'((9'h001 << ({1'b0, det_div_exp_in} + DIV_EXP_OFS)) - 9'h001);
   wire tick = (div_cnt_q == div_lim);
   wire cfg_mode = (st_q == ST_CONFIG);
   wire sel_read = (jtag_ir_in == READ_MSG_IR);
   wire sel_inj = (jtag_ir_in == FAULT_INJ_IR);
   wire low_done = (low_cnt_q == LOW_MIN_TICKS);
   wire [ADDR_W-1:0] cfg_addr = word_addr(cfg_f_q, cfg_w_q);
   wire [ADDR_W-1:0] chk_addr = word_addr(chk_f_q, chk_w_q);
   wire [WORD_W-1:0] a_data = cfg_mode ? cfg_word_in : mem[chk_addr];
   wire [CRC_W-1:0] a_next;
   wire [CRC_W-1:0] b_next;
   wire [4:0] s_bi = s_pos_q[4:0];
   wire [WIDX_W-1:0] s_cw = s_pos_q[POS_W-1:5];
   wire s_cross = ({1'b0, s_bi} + {4'h0, s_len_q}) > 6'h1F;
   wire [WORD_W-1:0] b_data = (s_word_q == s_cw) ? burst_mask(s_len_q, s_bi) : '0;
   wire s_last_cand = (s_pos_q == LAST_POS) && (s_len_q == 2'h3);
   wire [4:0] inj_bi = {inj_q.byte_pos[1:0], inj_q.bit_pos};
   wire [7:0] inj_w = inj_q.byte_pos[9:2];
   wire inj_ok = (inj_q.frame < 16'(NUM_FRAMES)) && (inj_w < 8'(FRAME_WORDS));
   wire inj_fire = (st_q == ST_START) && tick && inj_q.req && inj_ok;
   wire [ADDR_W-1:0] inj_addr = word_addr(inj_q.frame[FIDX_W-1:0], inj_w[WIDX_W-1:0]);
   wire [ADDR_W-1:0] inj_addr_nx = inj_addr + 1'b1;
   // a burst over a word edge spills into the next word; past the frame end it is cut
   wire [2*WORD_W-1:0] inj_mask = {{WORD_W{1'b0}}, burst_mask(inj_q.len_m1, 5'h00)} << inj_bi;
   wire inj_spill = (inj_mask[2*WORD_W-1:WORD_W] != '0) && (inj_w[WIDX_W-1:0] != LAST_W);
   wire cfg_mismatch = cfg_crc_valid_in && (crc_run_q != cfg_crc_in);
   wire [FIDX_W-1:0] next_f = (chk_f_q == LAST_F) ? '0 : chk_f_q + 1'b1;
   wire jt_req = (jtag_ctl_in.capture && sel_read) || jt_pend_q;
   wire usr_req = user_ctl_in.capture || usr_pend_q;
   // update registers load in the emr_valid_q cycle; capture waits that cycle out
   wire upd_ce = ~emr_valid_q;
   emr_t emr_d;

   assign emr_d.syndrome = syn_q;
   assign emr_d.frame = 16'(chk_f_q);
   assign emr_d.byte_pos = (hit_type_q == ETYPE_OTHER) ? '0 : 10'(hit_pos_q[POS_W-1:3]);
   assign emr_d.bit_pos = (hit_type_q == ETYPE_OTHER) ? '0 : hit_pos_q[2:0];
   assign emr_d.rsvd = 1'b0;
   assign emr_d.etype = hit_type_q;

   crc_word_step #(.W(CRC_W), .POLY(CRC_POLY)) u_crc_a
   (
      .crc_in(crc_run_q),
      .data_in(a_data),
      .crc_out(a_next)
   );

   // search engine runs the candidate burst alone through the crc
   crc_word_step #(.W(CRC_W), .POLY(CRC_POLY)) u_crc_b
   (
      .crc_in(s_crc_q),
      .data_in(b_data),
      .crc_out(b_next)
   );

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rc_meta_q <= 1'b0;
         rc_sync_q <= 1'b0;
      end
      else
      begin
         rc_meta_q <= reconfig_request_low_in;
         rc_sync_q <= rc_meta_q;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         div_cnt_q <= '0;
      else if (tick || div_cnt_q > div_lim)
         div_cnt_q <= '0;
      else
         div_cnt_q <= div_cnt_q + 8'h01;
   end

   // memory arrays carry no reset; they are filled during configuration
   always_ff @(posedge ref_clk_in)
   begin
      if (cfg_mode && !reconfig && cfg_word_valid_in)
         mem[cfg_addr] <= cfg_word_in;
      else if (inj_fire)
      begin
         mem[inj_addr] <= mem[inj_addr] ^ inj_mask[WORD_W-1:0];
         if (inj_spill)
            mem[inj_addr_nx] <= mem[inj_addr_nx] ^ inj_mask[2*WORD_W-1:WORD_W];
      end
      if (cfg_mode && !reconfig && cfg_crc_valid_in)
         crc_mem[cfg_f_q] <= crc_run_q;
   end

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         st_q <= ST_CONFIG;
         health_q <= 1'b1;
         err_q <= 1'b0;
         crc_run_q <= '0;
         syn_q <= '0;
         cfg_f_q <= '0;
         cfg_w_q <= '0;
         chk_f_q <= '0;
         chk_w_q <= '0;
         low_cnt_q <= '0;
         s_crc_q <= '0;
         s_word_q <= '0;
         s_pos_q <= '0;
         s_len_q <= '0;
         hit_pos_q <= '0;
         hit_type_q <= ETYPE_NONE;
         emr_q <= '0;
         emr_valid_q <= 1'b0;
      end
      else if (reconfig)
      begin
         st_q <= ST_CONFIG;
         health_q <= 1'b1;
         err_q <= 1'b0;
         crc_run_q <= '0;
         cfg_f_q <= '0;
         cfg_w_q <= '0;
         emr_valid_q <= 1'b0;
      end
      else
      begin
         emr_valid_q <= 1'b0;
         if (st_q != ST_CONFIG && st_q != ST_START && tick && !low_done)
            low_cnt_q <= low_cnt_q + 6'h01;
         case (st_q)
            ST_CONFIG:
            begin
               if (cfg_word_valid_in)
               begin
                  crc_run_q <= a_next;
                  cfg_w_q <= cfg_w_q + 1'b1;
               end
               else if (cfg_crc_valid_in)
               begin
                  if (cfg_mismatch)
                     health_q <= 1'b0;
                  crc_run_q <= '0;
                  cfg_w_q <= '0;
                  cfg_f_q <= cfg_f_q + 1'b1;
               end
               else if (cfg_done_in)
               begin
                  chk_f_q <= '0;
                  st_q <= ST_START;
               end
            end
            ST_START:
            begin
               if (tick)
               begin
                  err_q <= 1'b0;
                  crc_run_q <= '0;
                  chk_w_q <= '0;
                  low_cnt_q <= '0;
                  st_q <= ST_CALC;
               end
            end
            ST_CALC:
            begin
               if (tick)
               begin
                  crc_run_q <= a_next;
                  chk_w_q <= chk_w_q + 1'b1;
                  if (chk_w_q == LAST_W)
                  begin
                     syn_q <= a_next ^ crc_mem[chk_f_q];
                     st_q <= ST_EVAL;
                  end
               end
            end
            ST_EVAL:
            begin
               s_crc_q <= '0;
               s_word_q <= '0;
               s_pos_q <= '0;
               s_len_q <= '0;
               hit_type_q <= ETYPE_NONE;
               st_q <= (syn_q == '0) ? ST_WAIT : ST_SEARCH;
            end
            ST_SEARCH:
            begin
               // one candidate burst per frame pass; bursts never span two words
               if (!s_cross && s_word_q != LAST_W)
               begin
                  s_crc_q <= b_next;
                  s_word_q <= s_word_q + 1'b1;
               end
               else if (!s_cross && b_next == syn_q)
               begin
                  hit_pos_q <= s_pos_q;
                  hit_type_q <= 5'(s_len_q) + ETYPE_SINGLE;
                  st_q <= ST_WAIT;
               end
               else if (s_last_cand)
               begin
                  hit_pos_q <= '0;
                  hit_type_q <= ETYPE_OTHER;
                  st_q <= ST_WAIT;
               end
               else
               begin
                  s_crc_q <= '0;
                  s_word_q <= '0;
                  s_pos_q <= (s_pos_q == LAST_POS) ? '0 : s_pos_q + 1'b1;
                  if (s_pos_q == LAST_POS)
                     s_len_q <= s_len_q + 2'h1;
               end
            end
            ST_WAIT:
            begin
               if (low_done)
               begin
                  if (syn_q != '0)
                     st_q <= ST_REPORT;
                  else
                  begin
                     chk_f_q <= next_f;
                     st_q <= ST_START;
                  end
               end
            end
            ST_REPORT:
            begin
               emr_q <= emr_d;
               emr_valid_q <= 1'b1;
               st_q <= ST_FLAG;
            end
            ST_FLAG:
            begin
               err_q <= |syn_q;
               chk_f_q <= next_f;
               st_q <= ST_START;
            end
            default:
               st_q <= ST_CONFIG;
         endcase
      end
   end

   // message readout keeps running beside the checker
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         jt_upd_q <= '0;
         usr_upd_q <= '0;
         jt_sh_q <= '0;
         usr_sh_q <= '0;
         jt_pend_q <= 1'b0;
         usr_pend_q <= 1'b0;
      end
      else
      begin
         if (emr_valid_q)
         begin
            jt_upd_q <= emr_q;
            usr_upd_q <= emr_q;
         end
         jt_pend_q <= jt_req && !upd_ce;
         usr_pend_q <= usr_req && !upd_ce;
         if (jt_req && upd_ce)
            jt_sh_q <= jt_upd_q;
         else if (sel_read && jtag_ctl_in.shift)
            jt_sh_q <= {jtag_ctl_in.tdi, jt_sh_q[EMR_W-1:1]};
         if (usr_req && upd_ce)
            usr_sh_q <= usr_upd_q;
         else if (user_ctl_in.shift)
            usr_sh_q <= {1'b0, usr_sh_q[EMR_W-1:1]};
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         inj_sh_q <= '0;
         inj_q <= '0;
      end
      else
      begin
         if (sel_inj && jtag_ctl_in.shift)
            inj_sh_q <= {jtag_ctl_in.tdi, inj_sh_q[INJ_W-1:1]};
         // a new update outranks the clear of a request just applied
         if (sel_inj && jtag_ctl_in.update)
            inj_q <= inj_t'(inj_sh_q);
         else if (st_q == ST_START && tick)
            inj_q.req <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pin_q <= 1'b0;
         pin_oe_q <= 1'b0;
         tdo_q <= 1'b0;
      end
      else
      begin
         pin_q <= det_enable_in ? err_q : user_io_out_in;
         pin_oe_q <= det_enable_in | user_io_oe_in;
         tdo_q <= sel_read ? jt_sh_q[0] : (sel_inj ? inj_sh_q[0] : 1'b0);
      end
   end

   assign cfg_health_low_out = health_q;
   assign crc_error_out = err_q;
   assign crc_error_pin_out = pin_q;
   assign crc_error_pin_oe_out = pin_oe_q;
   assign jtag_tdo_out = tdo_q;
   assign user_data_out = usr_sh_q[0];

endmodule

`default_nettype wire

// ==== rtl/crc_chk_pkg.sv ====
package crc_chk_pkg;

   localparam int WORD_W = 32;
   localparam int CRC_W = 32;
   localparam int CRC_W_LEGACY = 16;
   localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
   localparam logic [15:0] CRC_POLY_LEGACY = 16'h8005;

   localparam int EMR_W = 67;
   localparam int EMR_W_LEGACY = 46;
   localparam int INJ_W = 32;

   localparam int IR_W = 10;
   localparam logic [IR_W-1:0] READ_MSG_IR = 10'h017;
   localparam logic [IR_W-1:0] FAULT_INJ_IR = 10'h015;

   // detection clock is ref clock / 2^n, n = code + 1
   localparam logic [3:0] DIV_EXP_OFS = 4'h1;
   localparam logic [5:0] LOW_MIN_TICKS = 6'h20;

   localparam logic [4:0] ETYPE_NONE = 5'h00;
   localparam logic [4:0] ETYPE_SINGLE = 5'h01;
   localparam logic [4:0] ETYPE_DOUBLE = 5'h02;
   localparam logic [4:0] ETYPE_TRIPLE = 5'h03;
   localparam logic [4:0] ETYPE_QUAD = 5'h04;
   localparam logic [4:0] ETYPE_OTHER = 5'h1F;

   typedef struct packed
   {
      logic [31:0] syndrome;
      logic [15:0] frame;
      logic [9:0] byte_pos;
      logic [2:0] bit_pos;
      logic rsvd;
      logic [4:0] etype;
   } emr_t;

   typedef struct packed
   {
      logic req;
      logic [1:0] len_m1;
      logic [15:0] frame;
      logic [9:0] byte_pos;
      logic [2:0] bit_pos;
   } inj_t;

   typedef struct packed
   {
      logic capture;
      logic shift;
      logic update;
      logic tdi;
   } jtag_ctl_t;

   typedef struct packed
   {
      logic capture;
      logic shift;
   } user_ctl_t;

endpackage

// ==== rtl/crc_word_step.sv ====
`timescale 1ns/1ps
`default_nettype none

// one word of a zero-seeded crc, msb first; no final xor keeps it linear
module crc_word_step
   import crc_chk_pkg::*;
#(
   parameter int W = CRC_W,
   parameter logic [W-1:0] POLY = CRC_POLY[W-1:0]
)
(
   input wire logic [W-1:0] crc_in,
   input wire logic [WORD_W-1:0] data_in,
   output logic [W-1:0] crc_out
);

   logic [W-1:0] c;
   logic fb;

   always_comb
   begin
      c = crc_in;
      fb = 1'b0;
      for (int i = WORD_W - 1; i >= 0; i--)
      begin
         fb = c[W-1] ^ data_in[i];
         c = {c[W-2:0], 1'b0} ^ ({W{fb}} & POLY);
      end
      crc_out = c;
   end

endmodule

`default_nettype wire

// ==== tb/config_memory_crc_checker_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

module crc_chk_sva
   import crc_chk_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic reconfig_request_low_in,
   input wire logic cfg_crc_valid_in,
   input wire logic det_enable_in,
   input wire logic [2:0] det_div_exp_in,
   input wire logic user_io_out_in,
   input wire logic user_io_oe_in,
   input wire logic cfg_health_low_out,
   input wire logic crc_error_out,
   input wire logic crc_error_pin_out,
   input wire logic crc_error_pin_oe_out
);
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   // clocks since the error flag was last high
   logic [15:0] low_q;

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         low_q <= 16'h0;
      else if (crc_error_out)
         low_q <= 16'h0;
      else if (low_q != 16'hFFFF)
         low_q <= low_q + 16'h1;
   end

   AST_HEALTH_STICKY: assert property (!cfg_health_low_out && reconfig_request_low_in
      |=> !cfg_health_low_out) else $error("health output recovered on its own");
   AST_HEALTH_CAUSE: assert property ($fell(cfg_health_low_out)
      |-> $past(cfg_crc_valid_in) || $past(cfg_crc_valid_in, 2))
      else $error("health output fell without a frame crc");
   // two clocks of slack for tick phase against the flag register
   AST_ERR_LOW_SPAN: assert property ($rose(crc_error_out)
      |-> low_q >= (16'h40 << det_div_exp_in) - 16'h2) else $error("error low span too short");
   AST_ERR_PULSE: assert property ($rose(crc_error_out) |-> ##[1:600] !crc_error_out)
      else $error("error flag did not drop");
   AST_CONFIG_QUIET: assert property (!reconfig_request_low_in [*5] |-> !crc_error_out)
      else $error("error flag high in reconfiguration");
   AST_PIN_FOLLOWS_ERR: assert property (!$past(rst_in) && $past(det_enable_in)
      |-> crc_error_pin_out == $past(crc_error_out)) else $error("pin does not follow error");
   AST_PIN_OE_DET: assert property (!$past(rst_in) && $past(det_enable_in)
      |-> crc_error_pin_oe_out) else $error("pin not driven in detection mode");
   AST_PIN_USER: assert property (!$past(rst_in) && !$past(det_enable_in)
      |-> crc_error_pin_out == $past(user_io_out_in) && crc_error_pin_oe_out == $past(user_io_oe_in))
      else $error("pin not carrying user data");
endmodule

bind config_memory_crc_checker crc_chk_sva crc_chk_sva_i (.ref_clk_in(ref_clk_in),
   .rst_in(rst_in), .reconfig_request_low_in(reconfig_request_low_in),
   .cfg_crc_valid_in(cfg_crc_valid_in), .det_enable_in(det_enable_in),
   .det_div_exp_in(det_div_exp_in), .user_io_out_in(user_io_out_in),
   .user_io_oe_in(user_io_oe_in), .cfg_health_low_out(cfg_health_low_out),
   .crc_error_out(crc_error_out), .crc_error_pin_out(crc_error_pin_out),
   .crc_error_pin_oe_out(crc_error_pin_oe_out));

`default_nettype wire

// ==== tb/config_memory_crc_checker_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module config_memory_crc_checker_tb_top;
   import crc_chk_pkg::*;

   localparam int NF = 4;
   localparam int FW = 4;

   typedef struct packed
   {
      inj_t inj;
      logic [4:0] etype;
      logic [2:0] dexp;
   } row_t;

   logic ref_clk_in = 1'h0;
   logic rst_in = 1'h1;
   logic rcfg_low = 1'h1;
   logic wvld = 1'h0;
   logic [WORD_W-1:0] word = 32'h0;
   logic cvld = 1'h0;
   logic [CRC_W-1:0] crc = 32'h0;
   logic done = 1'h0;
   logic det_en = 1'h1;
   logic [2:0] div_exp = 3'h0;
   logic uio_out = 1'h0;
   logic uio_oe = 1'h0;
   logic [IR_W-1:0] ir = 10'h0;
   jtag_ctl_t jctl;
   user_ctl_t uctl;
   logic health_low, err, pin, pin_oe, tdo, udata;
   int n_errors = 0;
   int checks = 0;
   int n;
   emr_t m;
   emr_t want;
   logic [63:0] msk;
   logic oth;
   // the last row crosses a word, so it must come out as an unlocated burst
   row_t rows [5] = '{
      '{'{1'h1, 2'h0, 16'h0, 10'h003, 3'h7}, ETYPE_SINGLE, 3'h0},
      '{'{1'h1, 2'h1, 16'h1, 10'h006, 3'h6}, ETYPE_DOUBLE, 3'h1},
      '{'{1'h1, 2'h2, 16'h2, 10'h00E, 3'h3}, ETYPE_TRIPLE, 3'h0},
      '{'{1'h1, 2'h3, 16'h3, 10'h004, 3'h4}, ETYPE_QUAD, 3'h2},
      '{'{1'h1, 2'h3, 16'h2, 10'h003, 3'h6}, ETYPE_OTHER, 3'h0}};

   always #5 ref_clk_in = ~ref_clk_in;

   config_memory_crc_checker #(.NUM_FRAMES(NF), .FRAME_WORDS(FW)) config_memory_crc_checker_i (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reconfig_request_low_in(rcfg_low),
      .cfg_word_valid_in(wvld), .cfg_word_in(word), .cfg_crc_valid_in(cvld), .cfg_crc_in(crc),
      .cfg_done_in(done), .det_enable_in(det_en), .det_div_exp_in(div_exp),
      .user_io_out_in(uio_out), .user_io_oe_in(uio_oe), .jtag_ir_in(ir), .jtag_ctl_in(jctl),
      .user_ctl_in(uctl), .cfg_health_low_out(health_low), .crc_error_out(err),
      .crc_error_pin_out(pin), .crc_error_pin_oe_out(pin_oe), .jtag_tdo_out(tdo),
      .user_data_out(udata));

   msg_reader msg_reader_i (.ref_clk_in(ref_clk_in), .jtag_tdo_in(tdo), .user_data_in(udata),
      .jtag_ctl_out(jctl), .user_ctl_out(uctl));

   // zero seed, msb first, no final xor: linear, so an error pattern alone gives the syndrome
   function automatic logic [CRC_W-1:0] crc_of(input int f, input logic dat, input int ew,
                                              input logic [2*WORD_W-1:0] mk);
      logic [CRC_W-1:0] c;
      logic [WORD_W-1:0] w;
      c = 32'h0;
      for (int k = 0; k < FW; k++)
      begin
         w = (dat ? {16'hA5C3, 8'(f), 8'(k)} : 32'h0) ^ (k == ew ? mk[WORD_W-1:0] : 32'h0)
             ^ (k == ew + 1 ? mk[2*WORD_W-1:WORD_W] : 32'h0);
         for (int b = WORD_W - 1; b >= 0; b--)
            c = {c[CRC_W-2:0], 1'h0} ^ ((c[CRC_W-1] ^ w[b]) ? CRC_POLY : 32'h0);
      end
      return c;
   endfunction

   task automatic check(input string what, input logic [EMR_W-1:0] seen,
                        input logic [EMR_W-1:0] exp_v);
      checks++;
      if (seen !== exp_v)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp_v, seen);
      end
   endtask

   task automatic configure(input int bad);
      rcfg_low <= 1'h0;
      repeat (6) @(posedge ref_clk_in);
      rcfg_low <= 1'h1;
      repeat (4) @(posedge ref_clk_in);
      for (int f = 0; f < NF; f++)
      begin
         for (int k = 0; k < FW; k++)
         begin
            wvld <= 1'h1;
            word <= {16'hA5C3, 8'(f), 8'(k)};
            @(posedge ref_clk_in);
         end
         wvld <= 1'h0;
         cvld <= 1'h1;
         crc <= crc_of(f, 1'h1, 0, 64'h0) ^ (f == bad ? 32'h1 : 32'h0);
         @(posedge ref_clk_in);
         cvld <= 1'h0;
      end
      done <= 1'h1;
      @(posedge ref_clk_in);
      done <= 1'h0;
      repeat (2) @(posedge ref_clk_in);
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      #900000;
      n_errors++;
      report_and_stop();
   end

   initial
   begin
      repeat (6) @(posedge ref_clk_in);
      rst_in <= 1'h0;
      foreach (rows[i])
      begin
         div_exp <= rows[i].dexp;
         configure(-1);
         ir <= FAULT_INJ_IR;
         msg_reader_i.inject(rows[i].inj);
         n = 0;
         while (err !== 1'h1 && n < 20000)
         begin
            @(posedge ref_clk_in);
            n++;
         end
         check("error flag", err, 1'h1);
         ir <= READ_MSG_IR;
         repeat (4) @(posedge ref_clk_in);
         msk = ((64'h1 << (rows[i].inj.len_m1 + 1)) - 64'h1) << {rows[i].inj.byte_pos[1:0],
                                                                rows[i].inj.bit_pos};
         // an unlocated burst still carries its full syndrome and frame but no byte or bit position
         oth = (rows[i].etype == ETYPE_OTHER);
         want = '{crc_of(0, 1'h0, int'(rows[i].inj.byte_pos[9:2]), msk), rows[i].inj.frame,
                  oth ? 10'h000 : rows[i].inj.byte_pos, oth ? 3'h0 : rows[i].inj.bit_pos,
                  1'h0, rows[i].etype};
         msg_reader_i.read_msg(1'h1, m);
         check("jtag message", m, want);
         msg_reader_i.read_msg(1'h0, m);
         check("user message", m, want);
      end
      rst_in <= 1'h1;
      @(posedge ref_clk_in);
      check("reset outputs", {health_low, err, pin, pin_oe, tdo, udata}, 6'h20);
      rst_in <= 1'h0;
      configure(1);
      check("health after bad crc", health_low, 1'h0);
      configure(-1);
      check("health after good crcs", health_low, 1'h1);
      cvld <= 1'h1;
      crc <= 32'h00000001;
      @(posedge ref_clk_in);
      cvld <= 1'h0;
      repeat (3) @(posedge ref_clk_in);
      check("health after late crc", health_low, 1'h1);
      n = 0;
      repeat (1500)
      begin
         @(posedge ref_clk_in);
         n += int'(err === 1'h1);
      end
      check("clean error count", 67'(n), 67'h0);
      det_en <= 1'h0;
      uio_out <= 1'h1;
      uio_oe <= 1'h1;
      repeat (3) @(posedge ref_clk_in);
      check("user pin", {pin, pin_oe}, 2'h3);
      det_en <= 1'h1;
      uio_oe <= 1'h0;
      repeat (3) @(posedge ref_clk_in);
      check("error pin", {pin, pin_oe}, 2'h1);
      report_and_stop();
   end
endmodule

`default_nettype wire

// ==== tb/msg_reader.sv ====
`timescale 1ns/1ps
`default_nettype none

module msg_reader
   import crc_chk_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic jtag_tdo_in,
   input wire logic user_data_in,
   output var jtag_ctl_t jtag_ctl_out,
   output var user_ctl_t user_ctl_out
);
   initial
   begin
      jtag_ctl_out = 4'h0;
      user_ctl_out = 2'h0;
   end

   // c = {capture, shift, update, tdi}; idle data line toggles so no stale bit looks valid
   task automatic strobe(input logic jt, input logic [3:0] c);
      @(posedge ref_clk_in);
      jtag_ctl_out <= jt ? c : {3'h0, ~c[0]};
      user_ctl_out <= jt ? 2'h0 : c[3:2];
      @(posedge ref_clk_in);
      jtag_ctl_out <= {3'h0, ~c[0]};
      user_ctl_out <= 2'h0;
   endtask

   // unloads at once after the flag; at division codes 0 and 1 the same frame comes round again before both reads end
   task automatic read_msg(input logic jt, output emr_t msg);
      logic [EMR_W-1:0] b;
      strobe(jt, 4'h8);
      for (int i = 0; i < EMR_W; i++)
      begin
         repeat (3) @(posedge ref_clk_in);
         b[i] = jt ? jtag_tdo_in : user_data_in;
         if (i < EMR_W - 1)
            strobe(jt, 4'h4);
      end
      msg = b;
   endtask

   task automatic inject(input inj_t r);
      for (int i = 0; i < INJ_W; i++)
         strobe(1'h1, {3'h2, r[i]});
      strobe(1'h1, 4'h2);
   endtask
endmodule

`default_nettype wire
